/* File: inc/bdw_pkg.sv */
// package for the bridge decode and wake configuration block
package bdw_pkg;
  // ==========================================================
  // register offsets (word addresses, each register in byte lane 0)
  localparam logic [3:0] OFF_CS_CTRL = 4'h0;
  localparam logic [3:0] OFF_SYS_CTRL = 4'h1;
  localparam logic [3:0] OFF_BUS_CTRL = 4'h2;
  localparam logic [3:0] OFF_WAKE_LO = 4'h3;
  localparam logic [3:0] OFF_WAKE_HI = 4'h4;
  localparam logic [3:0] OFF_EVT_STAT = 4'h5;
  localparam logic [3:0] OFF_EVT_CLR = 4'h6;
  localparam logic [3:0] OFF_EVT_EN = 4'h7;
  localparam logic [3:0] OFF_MODE_STAT = 4'h8;
  // ==========================================================
  // reset values and the system control write mask
  localparam logic [7:0] RST_CS_CTRL = 8'h33;
  localparam logic [7:0] RST_SYS_CTRL = 8'h04;
  localparam logic [7:0] RST_BUS_CTRL = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam logic [7:0] SYS_CTRL_WMASK = 8'hdf;
  // ==========================================================
  // field positions
  localparam int CS_EXT_BOOT = 7;
  localparam int CS_LOW_BOOT = 6;
  localparam int CS_WP = 5;
  localparam int CS_UP_BOOT = 4;
  localparam int CS_KBD = 1;
  localparam int CS_CLK = 0;
  localparam int SYS_REFRESH = 6;
  localparam int SYS_COPROC = 4;
  localparam int SYS_P92 = 2;
  localparam int SYS_KRST = 1;
  localparam int SYS_GATE = 0;
  localparam int BUS_IOREC = 2;
  localparam int BUS_EXT_ALE = 1;
  localparam int EVT_KRST = 0;
  localparam int EVT_WAKE = 1;
  localparam int EVT_COPROC = 2;
  // ==========================================================
  // encoded select values and decode constants
  localparam logic [1:0] XSEL_NONE = 2'h0;
  localparam logic [1:0] XSEL_CLOCK = 2'h1;
  localparam logic [1:0] XSEL_BOOT = 2'h3;
  localparam logic [31:0] EXT_BOOT_LO = 32'hfff80000;
  localparam logic [31:0] EXT_BOOT_HI = 32'hfffdffff;
  localparam logic [31:0] UP_BOOT_R4_LO = 32'hff800000;
  // revision code that selects the later upper boot decode; arbitrary value
  localparam logic [7:0] REV_ID_LATE = 8'h12;
  localparam logic [15:0] LOW_A = 16'hfffe;
  localparam logic [15:0] LOW_B = 16'hffee;
  localparam logic [15:0] LOW_C = 16'h000e;
  localparam logic [15:0] UP_A = 16'hffff;
  localparam logic [15:0] UP_B = 16'hffef;
  localparam logic [15:0] UP_C = 16'h000f;
  localparam logic [15:0] KBD_PORT_BASE = 16'h0060;
  localparam logic [15:0] CLK_PORT_BASE = 16'h0070;
  localparam logic [15:0] PORT_92 = 16'h0092;
  localparam logic [7:0] KBD_CMD_PORT = 8'h64;
  localparam logic [7:0] KBD_RESET_CMD = 8'hfe;
  localparam logic [7:0] KBD_GATE_ON_CMD = 8'hdf;
  localparam logic [7:0] KBD_GATE_OFF_CMD = 8'hdd;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int INIT_PULSE_CLKS = 5;
  localparam int HARD_RESET_OUTPUT_US = 1000;
  localparam int HARD_RESET_OUTPUT_CLKS = HARD_RESET_OUTPUT_US * (CLK_HZ / 1000000);
  localparam int IOREC_16_BCLK = 4;
  localparam int IOREC_8_BCLK = 8;
  // ==========================================================
  // grouped carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic io;
    logic wide16;
    logic [31:0] addr;
    logic [7:0] data;
  } bdw_cycle_s;
  typedef struct packed {
    logic boot_select;
    logic [1:0] encoded_select;
    logic claim_port92;
    logic forward_legacy;
  } bdw_select_s;
endpackage : bdw_pkg

/* File: rtl/bdw_config.sv */
// register bank for boot/keyboard/clock decode, legacy control and irq wake enables
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// ==========================================================
// Overview of operation
// R1: extended boot enable selects boot memory for FFF80000h..FFFDFFFFh, per processor mode
// R2: lower boot enable selects 64 KB at FFFE0000h, FFEE0000h or 000E0000h
// R3: write protect suppresses boot select for writes, in both processor modes
// R4: upper boot enable resets to 1; earlier revision decodes FFFF/FFEF/000F 64 KB regions
// R5: later revision upper boot decodes 000F0000h..000FFFFFh and FF800000h..FFFFFFFFh
// R6: keyboard select enable in first mode gives encoded select 11 on even ports 60-66h
// R7: clock-chip select enable in first mode gives encoded select 01 on ports 70-77h
// R8: coprocessor error enable makes shared pin the coprocessor error input
// R9: port 92 enable claims port 92 locally, otherwise forward to legacy bus
// R10: first mode keyboard reset emulation pulses init for more than 4 clocks
// R11: second mode keyboard reset emulation pulses hard reset for 1 ms
// R12: first mode gate emulation sets the gate output on command DFh and clears it on DDh
// R13: recovery bit adds 4 bus clocks after 16-bit, 8 after 8-bit I/O
// R14: low wake-enable bit n lets irq n break and drop power active
// R15: high wake-enable bits enable irq 8..15 as break events
// R16: software uses wake-enable registers only in first processor mode
// R17: chip select control reads 33h after reset
// R18: legacy system control resets 04h; bus control and wake enables reset 00h
// R19: always-zero reserved bit of legacy system control reads zero
module bdw_config
  import bdw_pkg::*;
#(
  parameter int HARD_RESET_OUTPUT_CYCLES = HARD_RESET_OUTPUT_CLKS,
  parameter logic [7:0] REVISION_ID = 8'h01 // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_mode_second,
  input wire bdw_cycle_s i_cycle,
  input wire logic i_bclk_tick,
  input wire logic [15:0] i_irq,
  input wire logic i_shared_pin,
  output bdw_select_s o_select,
  output logic o_io_recovery_busy,
  output logic o_ext_ale,
  output logic o_refresh_en,
  output logic o_coprocessor_error,
  output logic o_shared_alt,
  output logic o_init,
  output logic o_hard_reset_n,
  output logic o_gate_out,
  output logic o_power_mgmt_active_n,
  output logic o_irq
);
  // ==========================================================
  // registers
  logic [7:0] cs_reg, sys_reg, bus_reg, wlo_reg, whi_reg, evt_en_reg, evt_reg;
  logic ack_reg, wait_reg;
  logic [31:0] rdata_reg;
  logic [15:0] irq_prev_reg;
  logic [23:0] rst_cnt_reg;
  logic init_reg, hrst_n_reg, gate_reg, power_mgmt_active_n_reg, int_reg, busy_reg;
  logic [3:0] rec_cnt_reg;
  bdw_select_s sel_reg;
  logic copro_reg, alt_reg;

  // ==========================================================
  // bus decode: one wait state, answer on the second edge
  // writes land only at the edge where the master sees waitrequest low
  wire logic acc = (i_avs_read | i_avs_write) & ~ack_reg;
  wire logic wr_en = i_avs_write & ack_reg & i_avs_byteenable[0];
  wire logic [7:0] wd = i_avs_writedata[7:0];
  wire logic wr_cs = wr_en & (i_avs_address == OFF_CS_CTRL);
  wire logic wr_sys = wr_en & (i_avs_address == OFF_SYS_CTRL);
  wire logic wr_bus = wr_en & (i_avs_address == OFF_BUS_CTRL);
  wire logic wr_wlo = wr_en & (i_avs_address == OFF_WAKE_LO);
  wire logic wr_whi = wr_en & (i_avs_address == OFF_WAKE_HI);
  wire logic wr_clr = wr_en & (i_avs_address == OFF_EVT_CLR);
  wire logic wr_een = wr_en & (i_avs_address == OFF_EVT_EN);
  logic [7:0] rd_mux;
  always_comb begin
    case (i_avs_address)
      OFF_CS_CTRL: rd_mux = cs_reg;
      OFF_SYS_CTRL: rd_mux = sys_reg;
      OFF_BUS_CTRL: rd_mux = bus_reg;
      OFF_WAKE_LO: rd_mux = wlo_reg;
      OFF_WAKE_HI: rd_mux = whi_reg;
      OFF_EVT_STAT: rd_mux = evt_reg;
      OFF_EVT_EN: rd_mux = evt_en_reg;
      OFF_MODE_STAT: rd_mux = {REVISION_ID[5:0], ~power_mgmt_active_n_reg, i_mode_second};
      default: rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // address decode of the bridge cycle
  wire logic [31:0] a = i_cycle.addr;
  wire logic mem = i_cycle.valid & ~i_cycle.io;
  wire logic iocyc = i_cycle.valid & i_cycle.io;
  wire logic rev_late = (REVISION_ID == REV_ID_LATE);
  wire logic hit_ext = cs_reg[CS_EXT_BOOT] & (a >= EXT_BOOT_LO) & (a <= EXT_BOOT_HI); // R1
  wire logic hit_low = cs_reg[CS_LOW_BOOT] &
    ((a[31:16] == LOW_A) | (a[31:16] == LOW_B) | (a[31:16] == LOW_C)); // R2
  wire logic up_early = (a[31:16] == UP_A) | (a[31:16] == UP_B) | (a[31:16] == UP_C); // R4
  wire logic up_late = (a[31:16] == UP_C) | (a >= UP_BOOT_R4_LO); // R5
  wire logic hit_up = cs_reg[CS_UP_BOOT] & (rev_late ? up_late : up_early);
  wire logic boot_hit = mem & (hit_ext | hit_low | hit_up) &
    ~(cs_reg[CS_WP] & i_cycle.write); // R3
  wire logic kbd_hit = iocyc & ~i_mode_second & cs_reg[CS_KBD] &
    (a[15:3] == KBD_PORT_BASE[15:3]) & ~a[0]; // R6
  wire logic clk_hit = iocyc & ~i_mode_second & cs_reg[CS_CLK] &
    (a[15:3] == CLK_PORT_BASE[15:3]); // R7
  wire logic p92_hit = iocyc & (a[15:0] == PORT_92);
  bdw_select_s sel_next;
  always_comb begin
    sel_next.boot_select = boot_hit & i_mode_second; // R1
    sel_next.encoded_select = XSEL_NONE;
    if ((boot_hit & ~i_mode_second) | kbd_hit) begin
      sel_next.encoded_select = XSEL_BOOT; // R6
    end else if (clk_hit) begin
      sel_next.encoded_select = XSEL_CLOCK; // R7
    end
    sel_next.claim_port92 = p92_hit & sys_reg[SYS_P92]; // R9
    sel_next.forward_legacy = p92_hit & ~sys_reg[SYS_P92]; // R9
  end

  // ==========================================================
  // keyboard command emulation
  wire logic kcmd = iocyc & i_cycle.write & (a[15:0] == {8'h00, KBD_CMD_PORT});
  wire logic krst = kcmd & sys_reg[SYS_KRST] & (i_cycle.data == KBD_RESET_CMD);
  wire logic gate_cmd = kcmd & ~i_mode_second & sys_reg[SYS_GATE];
  wire logic [23:0] pulse_len = i_mode_second ? HARD_RESET_OUTPUT_CYCLES[23:0] : INIT_PULSE_CLKS[23:0];
  wire logic [15:0] irq_rise = i_irq & ~irq_prev_reg;
  wire logic wake_hit = |(irq_rise & {whi_reg, wlo_reg}); // R14 R15
  wire logic io_end = iocyc & ~p92_hit;
  wire logic [3:0] rec_len = i_cycle.wide16 ? IOREC_16_BCLK[3:0] : IOREC_8_BCLK[3:0];
  wire logic [3:0] rec_next = (io_end && bus_reg[BUS_IOREC]) ? rec_len : // R13
    (i_bclk_tick && rec_cnt_reg != 4'h0) ? rec_cnt_reg - 4'h1 : rec_cnt_reg;
  logic [7:0] evt_set;
  always_comb begin
    evt_set = 8'h00;
    evt_set[EVT_KRST] = krst;
    evt_set[EVT_WAKE] = wake_hit;
    evt_set[EVT_COPROC] = sys_reg[SYS_COPROC] & i_shared_pin;
  end
  wire logic [7:0] evt_next = (evt_reg & ~(wr_clr ? wd : 8'h00)) | evt_set;

  // ==========================================================
  // register writes and bus answer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cs_reg <= RST_CS_CTRL; // R17
      sys_reg <= RST_SYS_CTRL; // R18
      bus_reg <= RST_BUS_CTRL; // R18
      wlo_reg <= RST_WAKE; // R18
      whi_reg <= RST_WAKE; // R18
      evt_en_reg <= 8'h00;
      evt_reg <= 8'h00;
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= acc;
      wait_reg <= ~acc;
      if (acc && i_avs_read) begin
        rdata_reg <= {24'h00_0000, rd_mux};
      end
      if (wr_cs) begin
        cs_reg <= wd;
      end
      if (wr_sys) begin
        sys_reg <= wd & SYS_CTRL_WMASK; // R19
      end
      if (wr_bus) begin
        bus_reg <= wd;
      end
      if (wr_wlo) begin
        wlo_reg <= wd;
      end
      if (wr_whi) begin
        whi_reg <= wd;
      end
      if (wr_een) begin
        evt_en_reg <= wd;
      end
      evt_reg <= evt_next;
    end
  end

  // ==========================================================
  // output stage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_reg <= '0;
      irq_prev_reg <= 16'h0000;
      rst_cnt_reg <= 24'h00_0000;
      init_reg <= 1'b0;
      hrst_n_reg <= 1'b1;
      gate_reg <= 1'b0;
      power_mgmt_active_n_reg <= 1'b1;
      int_reg <= 1'b0;
      rec_cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      copro_reg <= 1'b0;
      alt_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      irq_prev_reg <= i_irq;
      int_reg <= |(evt_next & evt_en_reg);
      copro_reg <= sys_reg[SYS_COPROC] & i_shared_pin; // R8
      alt_reg <= ~sys_reg[SYS_COPROC] & i_shared_pin; // R8
      if (krst) begin
        rst_cnt_reg <= pulse_len;
        init_reg <= ~i_mode_second; // R10
        hrst_n_reg <= ~i_mode_second; // R11
      end else if (rst_cnt_reg != 24'h00_0000) begin
        rst_cnt_reg <= rst_cnt_reg - 24'h00_0001;
      end else begin
        init_reg <= 1'b0;
        hrst_n_reg <= 1'b1;
      end
      if (gate_cmd && i_cycle.data == KBD_GATE_ON_CMD) begin
        gate_reg <= 1'b1; // R12
      end else if (gate_cmd && i_cycle.data == KBD_GATE_OFF_CMD) begin
        gate_reg <= 1'b0; // R12
      end
      // power active drops on a break event in first mode; any valid bridge cycle sets it again
      if (wake_hit && !i_mode_second) begin
        power_mgmt_active_n_reg <= 1'b1; // R14 R15
      end else if (i_cycle.valid) begin
        power_mgmt_active_n_reg <= 1'b0;
      end
      rec_cnt_reg <= rec_next;
      busy_reg <= (rec_next != 4'h0); // R13
    end
  end

  assign o_avs_readdata = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_select = sel_reg;
  assign o_io_recovery_busy = busy_reg;
  assign o_ext_ale = bus_reg[BUS_EXT_ALE];
  assign o_refresh_en = sys_reg[SYS_REFRESH];
  assign o_coprocessor_error = copro_reg;
  assign o_shared_alt = alt_reg;
  assign o_init = init_reg;
  assign o_hard_reset_n = hrst_n_reg;
  assign o_gate_out = gate_reg;
  assign o_power_mgmt_active_n = power_mgmt_active_n_reg;
  assign o_irq = int_reg;
endmodule : bdw_config

/* File: test/bdw_config_properties.sv */
// assertion checker for the bridge decode and wake configuration block
`timescale 1ns/1ps
module bdw_config_properties
  import bdw_pkg::*;
#(
  parameter int HARD_RESET_OUTPUT_CYCLES = HARD_RESET_OUTPUT_CLKS
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_mode_second,
  input wire bdw_cycle_s i_cycle,
  input wire logic [15:0] i_irq,
  input wire bdw_select_s o_select,
  input wire logic o_io_recovery_busy,
  input wire logic o_init,
  input wire logic o_hard_reset_n,
  input wire logic o_gate_out,
  input wire logic o_power_mgmt_active_n
);
  // ==========================================================
  // helpers
  logic [15:0] irq_q;
  logic [15:0] lo_cnt;
  wire logic io_cyc = i_cycle.valid && i_cycle.io;
  wire logic kcmd = io_cyc && i_cycle.write && !i_mode_second;
  wire logic irq_rise = |(i_irq & ~irq_q);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_q <= '0;
      lo_cnt <= '0;
    end else begin
      irq_q <= i_irq;
      lo_cnt <= o_hard_reset_n ? 16'h0 : lo_cnt + 16'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_ack; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("no answer to request");
  property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer longer than a cycle");
  property p_clk; o_select.encoded_select == XSEL_CLOCK |->
    $past(io_cyc && !i_mode_second && i_cycle.addr[15:3] == 13'h000e); endproperty
  a_clk: assert property (p_clk) else $error("clock select without its port");
  property p_ioboot; $past(io_cyc) |-> !o_select.boot_select; endproperty
  a_ioboot: assert property (p_ioboot) else $error("boot select on io cycle");
  property p_p92; o_select.claim_port92 |-> $past(io_cyc && i_cycle.addr[15:0] == PORT_92); endproperty
  a_p92: assert property (p_p92) else $error("port 92 claimed wrongly");
  property p_init; $rose(o_init) |-> o_init [*5]; endproperty
  a_init: assert property (p_init) else $error("init pulse too short");
  property p_hrst; $rose(o_hard_reset_n) |-> lo_cnt >= HARD_RESET_OUTPUT_CYCLES; endproperty
  a_hrst: assert property (p_hrst) else $error("hard reset pulse too short");
  property p_gate; $changed(o_gate_out) |-> $past(kcmd) || $past(kcmd, 2); endproperty
  a_gate: assert property (p_gate) else $error("gate moved without command");
  property p_rec; $rose(o_io_recovery_busy) |-> $past(io_cyc) || $past(io_cyc, 2); endproperty
  a_rec: assert property (p_rec) else $error("recovery without io cycle");
  property p_wake; $rose(o_power_mgmt_active_n) |->
    $past(irq_rise) || $past(irq_rise, 2) || $past(irq_rise, 3); endproperty
  a_wake: assert property (p_wake) else $error("wake without irq rise");
  c_init: cover property ($rose(o_init));
  c_hrst: cover property ($fell(o_hard_reset_n));
  c_wake: cover property ($rose(o_power_mgmt_active_n));
endmodule : bdw_config_properties

/* File: test/tb_top.sv */
// self-checking bench for the bridge decode and wake configuration block
`timescale 1ns/1ps
module tb_top;
  import bdw_pkg::*;
  // shortened hard reset count keeps the run brief
  localparam int HR = 20;
  logic i_clk = 0, i_arst_n = 0, rd = 0, wr = 0, ms = 0, tick = 0, pin = 0;
  logic [3:0] ad = '0, be = 4'h1;
  logic [7:0] wd = '0, s = 8'h4c, cs;
  logic [15:0] irq = '0, ev;
  bdw_cycle_s cyc = '0;
  bdw_select_s sel, sel_late;
  logic [31:0] rdat, q;
  logic wq, busy, init, hrst_n, gate, pm_n, irqo, cerr, alt, ale, rfe;
  int num_errors = 0, n_checks = 0, n, e;
  logic [31:0] tab [16] = '{32'hfff80000, 32'hfffdffff, 32'hfffe0000, 32'hffee8000,
    32'h000e0001, 32'hffff0000, 32'hffeffffc, 32'h000fffff, 32'h000d0000, 32'hfff7ffff,
    32'h60, 32'h66, 32'h70, 32'h77, 32'h78, 32'h92};
  bdw_config #(.HARD_RESET_OUTPUT_CYCLES(HR)) uut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(ad), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata({24'h0, wd}), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_mode_second(ms), .i_cycle(cyc),
    .i_bclk_tick(tick), .i_irq(irq), .i_shared_pin(pin), .o_select(sel),
    .o_io_recovery_busy(busy), .o_ext_ale(ale), .o_refresh_en(rfe), .o_coprocessor_error(cerr),
    .o_shared_alt(alt), .o_init(init), .o_hard_reset_n(hrst_n), .o_gate_out(gate),
    .o_power_mgmt_active_n(pm_n), .o_irq(irqo));
  // second copy built as the later revision, so its upper boot decode is exercised too
  bdw_config #(.HARD_RESET_OUTPUT_CYCLES(HR), .REVISION_ID(REV_ID_LATE)) uut_late (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(ad), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata({24'h0, wd}), .i_avs_byteenable(be),
    .o_avs_readdata(), .o_avs_waitrequest(), .i_mode_second(ms), .i_cycle(cyc),
    .i_bclk_tick(tick), .i_irq(irq), .i_shared_pin(pin), .o_select(sel_late),
    .o_io_recovery_busy(), .o_ext_ale(), .o_refresh_en(), .o_coprocessor_error(),
    .o_shared_alt(), .o_init(), .o_hard_reset_n(), .o_gate_out(),
    .o_power_mgmt_active_n(), .o_irq());
  // ==========================================================
  // tasks and expectations
  function automatic logic [7:0] lf(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lf
  function automatic logic [1:0] xe(input logic [7:0] c, input logic w, io, late,
      input logic [31:0] a);
    logic hit;
    hit = !io && !(w && c[CS_WP]) && ((c[CS_EXT_BOOT] && a >= EXT_BOOT_LO && a <= EXT_BOOT_HI)
      || (c[CS_LOW_BOOT] && a[31:16] inside {LOW_A, LOW_B, LOW_C})
      || (c[CS_UP_BOOT] && (late ? (a[31:16] == UP_C || a >= UP_BOOT_R4_LO)
      : a[31:16] inside {UP_A, UP_B, UP_C})));
    if (hit || (io && c[CS_KBD] && a[15:0] inside {16'h60, 16'h62, 16'h64, 16'h66}))
      return XSEL_BOOT;
    if (io && c[CS_CLK] && a[15:3] == 13'h000e)
      return XSEL_CLOCK;
    return XSEL_NONE;
  endfunction : xe
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  // holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge i_clk);
    while (wq !== 1'b0) @(posedge i_clk);
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask : bus
  task automatic rdc(input logic [3:0] a, input logic [31:0] x);
    bus(0, a, 8'h0);
    chk(q, x);
  endtask : rdc
  task automatic cy(input logic w, io, w16, input logic [31:0] a, input logic [7:0] d);
    @(posedge i_clk);
    cyc <= '{1'b1, w, io, w16, a, d};
    @(posedge i_clk);
    cyc <= '0;
    #1;
  endtask : cy
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // ==========================================================
  // stimulus
  initial forever #20 i_clk = ~i_clk;
  always @(posedge i_clk) tick <= ~tick;
  initial begin
    repeat (60000) @(posedge i_clk);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1;
    rdc(OFF_CS_CTRL, 32'h33);
    rdc(OFF_SYS_CTRL, 32'h04);
    chk(rfe, 0);
    for (int i = 2; i < 5; i++) rdc(i[3:0], 32'h0);
    rdc(4'h9, 32'h0);
    bus(1, OFF_SYS_CTRL, 8'hff);
    rdc(OFF_SYS_CTRL, 32'hdf);
    chk(rfe, 1);
    bus(1, OFF_SYS_CTRL, 8'h04);
    be <= 4'h0;
    bus(1, OFF_WAKE_LO, 8'h5a);
    be <= 4'h1;
    rdc(OFF_WAKE_LO, 32'h0);
    repeat (4) begin
      s = lf(s);
      bus(1, OFF_WAKE_LO, s);
      rdc(OFF_WAKE_LO, {24'h0, s});
      bus(1, OFF_WAKE_HI, ~s);
      rdc(OFF_WAKE_HI, {24'h0, ~s});
    end
    for (int m = 0; m < 2; m++) begin
      ms <= m[0];
      for (int k = 0; k < 6; k++) begin
        s = lf(s);
        cs = k == 0 ? 8'hd3 : s;
        bus(1, OFF_CS_CTRL, cs);
        foreach (tab[i]) begin
          s = lf(s);
          cy(s[0], i > 9, 0, tab[i], s);
          if (m == 0) begin
            chk(sel.encoded_select, xe(cs, s[0], i > 9, 0, tab[i]));
            chk(sel_late.encoded_select, xe(cs, s[0], i > 9, 1, tab[i]));
          end else if (i < 10) begin
            chk(sel.boot_select, xe(cs, s[0], 0, 0, tab[i]) == XSEL_BOOT);
          end
        end
      end
    end
    ms <= 0;
    cy(0, 1, 0, 32'h92, 8'h0);
    chk({sel.claim_port92, sel.forward_legacy}, 2'b10);
    bus(1, OFF_SYS_CTRL, 8'h00);
    cy(0, 1, 0, 32'h92, 8'h0);
    chk({sel.claim_port92, sel.forward_legacy}, 2'b01);
    for (int m = 0; m < 2; m++) begin
      ms <= m[0];
      bus(1, OFF_SYS_CTRL, 8'h02);
      cy(1, 1, 0, 32'h64, KBD_RESET_CMD);
      n = 0;
      repeat (40) begin
        @(posedge i_clk);
        n += m ? hrst_n === 1'b0 : init === 1'b1;
      end
      if (m == 0) chk(n > 4 && n < 40, 1);
      else chk(n >= HR && n < 40, 1);
    end
    ms <= 0;
    bus(1, OFF_SYS_CTRL, 8'h01);
    for (int g = 1; g >= 0; g--) begin
      cy(1, 1, 0, 32'h64, g ? KBD_GATE_ON_CMD : KBD_GATE_OFF_CMD);
      repeat (2) @(posedge i_clk);
      chk(gate, g);
    end
    bus(1, OFF_BUS_CTRL, 8'h06);
    @(posedge i_clk);
    chk(ale, 1);
    for (int w = 0; w < 3; w++) begin
      if (w == 2) bus(1, OFF_BUS_CTRL, 8'h00);
      cy(0, 1, w == 1, 32'h300, 8'h0);
      e = w == 2 ? 0 : (w ? IOREC_16_BCLK : IOREC_8_BCLK);
      n = 0;
      repeat (40) begin
        @(posedge i_clk);
        n += busy === 1'b1 && tick === 1'b1;
      end
      chk(n == e || (e > 0 && n == e + 1), 1);
    end
    bus(1, OFF_EVT_CLR, 8'h07);
    bus(1, OFF_EVT_EN, 8'h02);
    for (int k = 0; k < 5; k++) begin
      s = lf(s);
      ev = 16'h1 << s[3:0];
      bus(1, OFF_WAKE_LO, k ? ev[7:0] : 8'h0);
      bus(1, OFF_WAKE_HI, k ? ev[15:8] : 8'h0);
      cy(0, 0, 0, 32'h0, 8'h0);
      chk(pm_n, 0);
      irq <= ev;
      repeat (4) @(posedge i_clk);
      chk({pm_n, irqo}, k ? 2'b11 : 2'b00);
      bus(1, OFF_EVT_EN, 8'h00);
      // the enable lands at the answering edge and the interrupt flop follows one edge later
      repeat (2) @(posedge i_clk);
      chk(irqo, 0);
      rdc(OFF_EVT_STAT, k ? 32'h2 : 32'h0);
      bus(1, OFF_EVT_CLR, 8'h02);
      bus(1, OFF_EVT_EN, 8'h02);
      irq <= '0;
      rdc(OFF_EVT_STAT, 32'h0);
      chk(irqo, 0);
    end
    for (int b = 0; b < 4; b++) begin
      if (b == 0 || b == 2) bus(1, OFF_SYS_CTRL, b ? 8'h00 : 8'h10);
      pin <= b[0];
      repeat (3) @(posedge i_clk);
      chk(b < 2 ? cerr : alt, b[0]);
    end
    // a second reset in mid-run must bring back the chip select and system control defaults that software changed
    i_arst_n <= 0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1;
    rdc(OFF_CS_CTRL, 32'h33);
    rdc(OFF_SYS_CTRL, 32'h04);
    conclude();
  end
endmodule : tb_top
bind bdw_config bdw_config_properties #(.HARD_RESET_OUTPUT_CYCLES(HARD_RESET_OUTPUT_CYCLES)) u_props (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_mode_second(i_mode_second), .i_cycle(i_cycle),
  .i_irq(i_irq), .o_select(o_select), .o_io_recovery_busy(o_io_recovery_busy),
  .o_init(o_init), .o_hard_reset_n(o_hard_reset_n), .o_gate_out(o_gate_out),
  .o_power_mgmt_active_n(o_power_mgmt_active_n));
